/* rtl/nvm_pkg.sv */
package nvm_pkg;
    // Clock and operation timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int BUF_ERASE_NS   = 500;
    localparam int PAGE_ERASE_NS  = 3000;
    localparam int PAGE_WRITE_NS  = 3000;
    localparam int BUF_ERASE_CYC  =
        (BUF_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ERASE_CYC =
        (PAGE_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_WRITE_CYC =
        (PAGE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W        = 8;
    localparam int UNLOCK_CYC     = 16;
    localparam int MAP_STALL_CYC  = 3;

    // EEPROM geometry
    localparam int BYTE_W     = 5;
    localparam int PAGE_W     = 3;
    localparam int EE_ADDR_W  = BYTE_W + PAGE_W;
    localparam int PAGE_SIZE  = 1 << BYTE_W;
    localparam int PAGE_COUNT = 1 << PAGE_W;
    localparam int EE_SIZE    = 1 << EE_ADDR_W;
    localparam int CMD_W      = 7;
    localparam int CORE_AW    = 16;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Command codes
    localparam logic [CMD_W-1:0] CMD_NOP         = 7'h00;
    localparam logic [CMD_W-1:0] CMD_LOAD_BUF    = 7'h33;
    localparam logic [CMD_W-1:0] CMD_ERASE_BUF   = 7'h36;
    localparam logic [CMD_W-1:0] CMD_ERASE_PAGE  = 7'h32;
    localparam logic [CMD_W-1:0] CMD_WRITE_PAGE  = 7'h34;
    localparam logic [CMD_W-1:0] CMD_ERASE_WRITE = 7'h35;
    localparam logic [CMD_W-1:0] CMD_ERASE_ALL   = 7'h30;
    localparam logic [CMD_W-1:0] CMD_READ        = 7'h06;

    // Core-side addresses of the controller
    localparam logic [CORE_AW-1:0] IO_PTR_LO  = 16'h01C0;
    localparam logic [CORE_AW-1:0] IO_DATA    = 16'h01C4;
    localparam logic [CORE_AW-1:0] IO_CMD     = 16'h01CA;
    localparam logic [CORE_AW-1:0] IO_CTRL1   = 16'h01CB;
    localparam logic [CORE_AW-1:0] IO_CTRL2   = 16'h01CC;
    localparam logic [CORE_AW-1:0] IO_STATUS  = 16'h01CF;
    localparam logic [CORE_AW-1:0] IO_UNLOCK  = 16'h0034;
    localparam logic [7:0]         MAP_HI     = 8'h10;
    localparam logic [7:0]         UNLOCK_KEY = 8'hD8;
    localparam int LAUNCH_BIT = 0;
    localparam int MAP_EN_BIT = 3;
    localparam int BUSY_BIT   = 7;

    // Bridge registers on AHB-Lite
    localparam logic [7:0] H_ADDR_OFS = 8'h00;
    localparam logic [7:0] H_DATA_OFS = 8'h04;
    localparam logic [7:0] H_GO_OFS   = 8'h08;
    localparam logic [7:0] H_STAT_OFS = 8'h0C;
    localparam int GO_WRITE_BIT  = 0;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_DATA_LSB = 8;
endpackage : nvm_pkg

/* rtl/nvm_if.sv */
`timescale 1ns/10ps
interface nvm_if;
    logic                        req;
    logic                        we;
    logic [nvm_pkg::CORE_AW-1:0] addr;
    logic [7:0]                  wdata;
    logic                        ready;
    logic [7:0]                  rdata;
    logic                        rvalid;

    modport core (output req, we, addr, wdata,
                  input  ready, rdata, rvalid);
    modport nvm  (input  req, we, addr, wdata,
                  output ready, rdata, rvalid);
endinterface : nvm_if

/* rtl/eeprom_nvm_device.sv */
// Contract
// - Pointer/data path and memory-mapped path both exist
// - Pointer low bits byte, high bits page
// - Mapped store loads buffer slot by low bits
// - Mapped buffer load stalls core three cycles
// - Mapping disables controller load and read
// - Launch bit executes currently held command
// - Triggers need unlock unless external programmer
// - Seven-bit command, zero is no operation
// - Load command tags slot on data write
// - Software repeats pointer then data writes
// - Buffer erase clears buffer, busy meanwhile
// - Page erase touches only tagged locations
// - Page write programs only tagged bytes
// - Erase-and-write atomic, busy throughout
// - Whole erase hits tagged positions, all pages
// - Read command loads byte into data register
// - Busy held from launch until finish
// - Software sets command, pointer, then launches
// - Byte or page writes, single-byte reads
`timescale 1ns/10ps
module eeprom_nvm_device (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic ext_prog_pin,
    output logic      busy,
    nvm_if.nvm        bus
);
    typedef enum logic [4:0] {
        ST_IDLE      = 5'b00001,
        ST_BUF_ERASE = 5'b00010,
        ST_PG_ERASE  = 5'b00100,
        ST_PG_WRITE  = 5'b01000,
        ST_ALL_ERASE = 5'b10000
    } state_t;

    state_t                            state_r;
    logic                              ext_meta_r;
    logic                              ext_sync_r;
    logic [nvm_pkg::EE_ADDR_W-1:0]     ptr_r;
    logic [7:0]                        data_r;
    logic [nvm_pkg::CMD_W-1:0]         cmd_r;
    logic                              map_en_r;
    logic [4:0]                        unlock_r;
    logic [1:0]                        stall_r;
    logic [nvm_pkg::TIMER_W-1:0]       timer_r;
    logic [nvm_pkg::PAGE_W-1:0]        page_r;
    logic                              chain_r;
    logic [7:0]                        rdata_r;
    logic                              rvalid_r;
    logic [7:0]                        buf_data [nvm_pkg::PAGE_SIZE];
    logic [nvm_pkg::PAGE_SIZE-1:0]     buf_tag;
    logic [7:0]                        ee_mem [nvm_pkg::EE_SIZE];
    logic                              accept;
    logic                              wr_acc;
    logic                              map_hit;
    logic                              unlocked;
    logic                              is_busy;
    logic                              launch;
    logic                              data_trig;
    logic                              map_load;
    logic                              read_go;
    logic                              op_done;
    logic [7:0]                        rd_mux;

    // External programmer strap synchroniser
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
        end
        else if (ce)
        begin
            ext_meta_r <= ext_prog_pin;
            ext_sync_r <= ext_meta_r;
        end
    end

    assign accept    = bus.req && bus.ready;
    assign wr_acc    = accept && bus.we;
    assign map_hit   = bus.addr[15:8] == nvm_pkg::MAP_HI;
    assign unlocked  = (unlock_r != 5'h0) || ext_sync_r;
    assign is_busy   = state_r != ST_IDLE;
    assign busy      = is_busy;
    assign launch    = wr_acc && bus.addr == nvm_pkg::IO_CTRL1
                       && bus.wdata[nvm_pkg::LAUNCH_BIT]
                       && unlocked && !is_busy;
    assign data_trig = wr_acc && bus.addr == nvm_pkg::IO_DATA
                       && cmd_r == nvm_pkg::CMD_LOAD_BUF
                       && unlocked && !is_busy && !map_en_r;
    assign map_load  = wr_acc && map_hit && map_en_r && !is_busy;
    assign read_go   = launch && cmd_r == nvm_pkg::CMD_READ
                       && !map_en_r;
    assign op_done   = is_busy && timer_r == 8'h01;
    assign bus.ready = ce && stall_r == 2'h0;

    // Timed unlock window
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            unlock_r <= 5'h0;
        else if (ce)
        begin
            if (wr_acc && bus.addr == nvm_pkg::IO_UNLOCK
                && bus.wdata == nvm_pkg::UNLOCK_KEY)
                unlock_r <= 5'(nvm_pkg::UNLOCK_CYC);
            else if (unlock_r != 5'h0)
                unlock_r <= unlock_r - 5'h1;
        end
    end

    // Pointer, command and mapping control
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_r    <= 8'h00;
            cmd_r    <= nvm_pkg::CMD_NOP;
            map_en_r <= 1'b0;
        end
        else if (ce && wr_acc)
        begin
            if (bus.addr == nvm_pkg::IO_PTR_LO)
                ptr_r <= bus.wdata;
            if (bus.addr == nvm_pkg::IO_CMD)
                cmd_r <= bus.wdata[nvm_pkg::CMD_W-1:0];
            if (bus.addr == nvm_pkg::IO_CTRL2)
                map_en_r <= bus.wdata[nvm_pkg::MAP_EN_BIT];
        end
    end

    // Data byte register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            data_r <= 8'h00;
        else if (ce)
        begin
            if (read_go)
                data_r <= ee_mem[ptr_r];
            else if (wr_acc && bus.addr == nvm_pkg::IO_DATA)
                data_r <= bus.wdata;
        end
    end

    // Stall after mapped buffer load
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            stall_r <= 2'h0;
        else if (ce)
        begin
            if (map_load)
                stall_r <= 2'(nvm_pkg::MAP_STALL_CYC);
            else if (stall_r != 2'h0)
                stall_r <= stall_r - 2'h1;
        end
    end

    // Operation sequencer
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            timer_r <= 8'h00;
            page_r  <= 3'h0;
            chain_r <= 1'b0;
        end
        else if (ce)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (launch)
                    begin
                        page_r  <= ptr_r[nvm_pkg::EE_ADDR_W-1:
                                         nvm_pkg::BYTE_W];
                        chain_r <= cmd_r == nvm_pkg::CMD_ERASE_WRITE;
                        case (cmd_r)
                            nvm_pkg::CMD_ERASE_BUF:
                            begin
                                state_r <= ST_BUF_ERASE;
                                timer_r <= 8'(nvm_pkg::BUF_ERASE_CYC);
                            end
                            nvm_pkg::CMD_ERASE_PAGE,
                            nvm_pkg::CMD_ERASE_WRITE:
                            begin
                                state_r <= ST_PG_ERASE;
                                timer_r <= 8'(nvm_pkg::PAGE_ERASE_CYC);
                            end
                            nvm_pkg::CMD_WRITE_PAGE:
                            begin
                                state_r <= ST_PG_WRITE;
                                timer_r <= 8'(nvm_pkg::PAGE_WRITE_CYC);
                            end
                            nvm_pkg::CMD_ERASE_ALL:
                            begin
                                state_r <= ST_ALL_ERASE;
                                timer_r <= 8'(nvm_pkg::PAGE_ERASE_CYC);
                            end
                            default:
                                state_r <= ST_IDLE;
                        endcase
                    end
                end
                ST_PG_ERASE:
                begin
                    if (op_done && chain_r)
                    begin
                        state_r <= ST_PG_WRITE;
                        timer_r <= 8'(nvm_pkg::PAGE_WRITE_CYC);
                        chain_r <= 1'b0;
                    end
                    else if (op_done)
                        state_r <= ST_IDLE;
                    else
                        timer_r <= timer_r - 8'h01;
                end
                ST_BUF_ERASE,
                ST_PG_WRITE,
                ST_ALL_ERASE:
                begin
                    if (op_done)
                        state_r <= ST_IDLE;
                    else
                        timer_r <= timer_r - 8'h01;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Page buffer with per-slot tags
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            buf_tag <= '0;
            for (int i = 0; i < nvm_pkg::PAGE_SIZE; i++)
                buf_data[i] <= nvm_pkg::ERASED_BYTE;
        end
        else if (ce)
        begin
            if (op_done && state_r == ST_BUF_ERASE)
            begin
                buf_tag <= '0;
                for (int i = 0; i < nvm_pkg::PAGE_SIZE; i++)
                    buf_data[i] <= nvm_pkg::ERASED_BYTE;
            end
            else if (data_trig)
            begin
                buf_data[ptr_r[nvm_pkg::BYTE_W-1:0]] <=
                    data_r_in();
                buf_tag[ptr_r[nvm_pkg::BYTE_W-1:0]]  <= 1'b1;
            end
            else if (map_load)
            begin
                buf_data[bus.addr[nvm_pkg::BYTE_W-1:0]] <=
                    bus.wdata;
                buf_tag[bus.addr[nvm_pkg::BYTE_W-1:0]]  <= 1'b1;
            end
        end
    end

    function automatic logic [7:0] data_r_in();
        data_r_in = bus.wdata;
    endfunction : data_r_in

    // Nonvolatile array, no reset
    always_ff @(posedge clock)
    begin
        if (ce && op_done)
        begin
            for (int i = 0; i < nvm_pkg::PAGE_SIZE; i++)
            begin
                if (buf_tag[i] && state_r == ST_PG_ERASE)
                    ee_mem[{page_r, nvm_pkg::BYTE_W'(i)}] <=
                        nvm_pkg::ERASED_BYTE;
                if (buf_tag[i] && state_r == ST_PG_WRITE)
                    ee_mem[{page_r, nvm_pkg::BYTE_W'(i)}] <=
                        buf_data[i];
                for (int p = 0; p < nvm_pkg::PAGE_COUNT; p++)
                    if (buf_tag[i] && state_r == ST_ALL_ERASE)
                        ee_mem[{nvm_pkg::PAGE_W'(p), nvm_pkg::BYTE_W'(i)}]
                            <= nvm_pkg::ERASED_BYTE;
            end
        end
    end

    // Core read data
    always_comb
    begin
        rd_mux = 8'h00;
        if (map_hit)
            rd_mux = map_en_r ? ee_mem[bus.addr[7:0]] : 8'h00;
        else
            case (bus.addr)
                nvm_pkg::IO_PTR_LO: rd_mux = ptr_r;
                nvm_pkg::IO_DATA:   rd_mux = data_r;
                nvm_pkg::IO_CMD:    rd_mux = {1'b0, cmd_r};
                nvm_pkg::IO_CTRL2:  rd_mux = {4'h0, map_en_r, 3'h0};
                nvm_pkg::IO_STATUS: rd_mux = {is_busy, 7'h00};
                default:            rd_mux = 8'h00;
            endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else if (ce)
        begin
            rvalid_r <= accept && !bus.we;
            if (accept && !bus.we)
                rdata_r <= rd_mux;
        end
    end

    assign bus.rdata  = rdata_r;
    assign bus.rvalid = rvalid_r;
endmodule : eeprom_nvm_device

/* rtl/nvm_core_bridge.sv */
`timescale 1ns/10ps
module nvm_core_bridge (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    nvm_if.core              bus
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_REQ  = 3'b010,
        H_WAIT = 3'b100
    } hstate_t;

    hstate_t                       state_r;
    logic                          dp_wr_r;
    logic [7:0]                    dp_addr_r;
    logic [31:0]                   hrdata_r;
    logic [nvm_pkg::CORE_AW-1:0]   addr_r;
    logic [7:0]                    wdata_r;
    logic [7:0]                    last_r;
    logic                          we_r;
    logic                          ap_valid;
    logic                          go;
    logic                          pending;
    logic [31:0]                   rd_mux;

    assign ap_valid  = hsel && htrans[1] && hready;
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign pending   = state_r != H_IDLE;
    assign go        = dp_wr_r && dp_addr_r == nvm_pkg::H_GO_OFS
                       && !pending;

    // Address phase capture
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end
        else if (ce)
        begin
            dp_wr_r   <= ap_valid && hwrite;
            dp_addr_r <= haddr[7:0];
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            nvm_pkg::H_ADDR_OFS: rd_mux = {16'h0000, addr_r};
            nvm_pkg::H_DATA_OFS: rd_mux = {24'h00_0000, wdata_r};
            nvm_pkg::H_STAT_OFS: rd_mux = {16'h0000, last_r, 7'h00, pending};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            hrdata_r <= 32'h0000_0000;
        else if (ce && ap_valid && !hwrite)
            hrdata_r <= rd_mux;
    end

    // Access registers
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_r  <= 16'h0000;
            wdata_r <= 8'h00;
            we_r    <= 1'b0;
        end
        else if (ce && dp_wr_r)
        begin
            if (dp_addr_r == nvm_pkg::H_ADDR_OFS)
                addr_r <= hwdata[nvm_pkg::CORE_AW-1:0];
            if (dp_addr_r == nvm_pkg::H_DATA_OFS)
                wdata_r <= hwdata[7:0];
            if (go)
                we_r <= hwdata[nvm_pkg::GO_WRITE_BIT];
        end
    end

    // Core access sequencer, one access at a time in software order
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= H_IDLE;
            last_r  <= 8'h00;
        end
        else if (ce)
        begin
            case (state_r)
                H_IDLE:
                    if (go)
                        state_r <= H_REQ;
                H_REQ:
                    if (bus.ready)
                        state_r <= we_r ? H_IDLE : H_WAIT;
                H_WAIT:
                    if (bus.rvalid)
                    begin
                        last_r  <= bus.rdata;
                        state_r <= H_IDLE;
                    end
                default:
                    state_r <= H_IDLE;
            endcase
        end
    end

    assign bus.req   = state_r == H_REQ;
    assign bus.we    = we_r;
    assign bus.addr  = addr_r;
    assign bus.wdata = wdata_r;
endmodule : nvm_core_bridge

/* test/eeprom_nvm_monitor.sv */
`timescale 1ns/10ps
module eeprom_nvm_monitor (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        busy,
    input wire logic        req,
    input wire logic        we,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        ready,
    input wire logic [7:0]  rdata,
    input wire logic        rvalid
);
    logic       acc;
    logic       wr;
    logic       go;
    logic       map_r;
    logic [6:0] cmd_r;
    logic [7:0] cnt_r;
    assign acc = req && ready;
    assign wr  = acc && we;
    assign go  = wr && addr == nvm_pkg::IO_CTRL1 && wdata[0];
    // Held command code
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) cmd_r <= 7'h00;
        else if (wr && addr == nvm_pkg::IO_CMD) cmd_r <= wdata[6:0];
    end
    // Mapping enable
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) map_r <= 1'b0;
        else if (wr && addr == nvm_pkg::IO_CTRL2) map_r <= wdata[3];
    end
    // Busy length
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) cnt_r <= 8'h00;
        else cnt_r <= busy ? cnt_r + 8'h01 : 8'h00;
    end
    function automatic logic [7:0] dur(input logic [6:0] c);
        if (c == nvm_pkg::CMD_ERASE_BUF) return 8'h0A;
        if (c == nvm_pkg::CMD_ERASE_WRITE) return 8'h78;
        return 8'h3C;
    endfunction : dur
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    property p_rd_ans;
        acc && !we |=> rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read unanswered");
    property p_rv_src;
        rvalid |-> $past(acc && !we);
    endproperty
    a_rv_src: assert property (p_rv_src)
        else $error("stray rvalid");
    property p_rd_hold;
        !rvalid |-> $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("rdata moved");
    property p_stall;
        wr && addr[15:8] == nvm_pkg::MAP_HI && map_r && !busy
            |=> !ready [*3] ##1 ready;
    endproperty
    a_stall: assert property (p_stall)
        else $error("bad stall");
    property p_go_busy;
        $rose(busy) |-> $past(go);
    endproperty
    a_go_busy: assert property (p_go_busy)
        else $error("busy no launch");
    property p_busy_min;
        $rose(busy) |-> busy [*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("busy short");
    property p_busy_len;
        $fell(busy) |-> cnt_r == dur(cmd_r);
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy len");
    property p_no_busy;
        go && !busy
            && (cmd_r == nvm_pkg::CMD_READ || cmd_r == nvm_pkg::CMD_NOP)
            |=> !busy [*2];
    endproperty
    a_no_busy: assert property (p_no_busy)
        else $error("busy on read");
    property p_ld_nb;
        wr && addr == nvm_pkg::IO_DATA
            && cmd_r == nvm_pkg::CMD_LOAD_BUF && !busy
            |=> !busy;
    endproperty
    a_ld_nb: assert property (p_ld_nb)
        else $error("busy on load");
endmodule : eeprom_nvm_monitor

/* test/tb_eeprom_nvm_command_access.sv */
`timescale 1ns/10ps
module tb_eeprom_nvm_command_access;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        ext = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hrdy;
    logic [31:0] hrdata;
    logic        busy;
    logic [7:0]  bcnt = 8'h00;
    logic [31:0] st;
    int          err_count = 0;
    int          checks = 0;
    nvm_if nif ();
    nvm_core_bridge nvm_core_bridge_i (.clock(clock), .rstn(rstn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
        .hresp(), .hrdata(hrdata), .bus(nif));
    eeprom_nvm_device eeprom_nvm_device_i (.clock(clock), .rstn(rstn),
        .ce(1'b1), .ext_prog_pin(ext), .busy(busy), .bus(nif));
    eeprom_nvm_monitor eeprom_nvm_monitor_i (.clock(clock), .rstn(rstn),
        .busy(busy), .req(nif.req), .we(nif.we), .addr(nif.addr),
        .wdata(nif.wdata), .ready(nif.ready), .rdata(nif.rdata),
        .rvalid(nif.rvalid));
    initial forever #25 clock = ~clock;
    always @(posedge clock) if (busy === 1'b1) bcnt <= bcnt + 8'h01;
    task automatic conclude();
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // One AHB-Lite single transfer
    task automatic ahb(input logic w, input logic [7:0] o,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, o};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clock);
        while (hrdy !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hrdy !== 1'b1) @(posedge clock);
        st = hrdata;
    endtask : ahb
    // One core access through the bridge
    task automatic core(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        ahb(1'b1, nvm_pkg::H_ADDR_OFS, {16'h0000, a});
        ahb(1'b1, nvm_pkg::H_DATA_OFS, {24'h000000, d});
        ahb(1'b1, nvm_pkg::H_GO_OFS, {31'h0, w});
        ahb(1'b0, nvm_pkg::H_STAT_OFS, 32'h0);
        while (st[0] !== 1'b0) ahb(1'b0, nvm_pkg::H_STAT_OFS, 32'h0);
    endtask : core
    task automatic ld(input logic [7:0] p, input logic [7:0] d);
        core(1'b1, nvm_pkg::IO_PTR_LO, p);
        core(1'b1, nvm_pkg::IO_DATA, d);
    endtask : ld
    // Command, pointer, launch, then busy length
    task automatic op(input logic [6:0] c, input logic [7:0] p,
                      input logic [7:0] e);
        logic [7:0] s;
        core(1'b1, nvm_pkg::IO_CMD, {1'b0, c});
        core(1'b1, nvm_pkg::IO_PTR_LO, p);
        s = bcnt;
        core(1'b1, nvm_pkg::IO_UNLOCK, nvm_pkg::UNLOCK_KEY);
        core(1'b1, nvm_pkg::IO_CTRL1, 8'h01);
        repeat (130) @(posedge clock);
        chk("busy cycles", e, bcnt - s);
    endtask : op
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        op(nvm_pkg::CMD_READ, p, 8'h00);
        core(1'b0, nvm_pkg::IO_DATA, 8'h00);
        chk("eeprom byte", e, st[15:8]);
    endtask : rd
    initial
    begin
        #2000000;
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        core(1'b1, nvm_pkg::IO_CMD, {1'b0, nvm_pkg::CMD_LOAD_BUF});
        for (int i = 0; i < 32; i++) ld(8'(i), 8'hFF);
        op(nvm_pkg::CMD_ERASE_ALL, 8'h00, 8'h3C);
        rd(8'hE5, 8'hFF);
        op(nvm_pkg::CMD_ERASE_BUF, 8'h00, 8'h0A);
        core(1'b1, nvm_pkg::IO_CMD, {1'b0, nvm_pkg::CMD_LOAD_BUF});
        ld(8'h02, 8'hA5);
        chk("busy", 8'h00, {7'h00, busy});
        ld(8'h07, 8'h3C);
        op(nvm_pkg::CMD_WRITE_PAGE, 8'h40, 8'h3C);
        rd(8'h42, 8'hA5);
        rd(8'h47, 8'h3C);
        rd(8'h43, 8'hFF);
        op(nvm_pkg::CMD_ERASE_WRITE, 8'h60, 8'h78);
        rd(8'h67, 8'h3C);
        op(nvm_pkg::CMD_ERASE_PAGE, 8'h60, 8'h3C);
        rd(8'h62, 8'hFF);
        rd(8'h42, 8'hA5);
        op(nvm_pkg::CMD_ERASE_BUF, 8'h00, 8'h0A);
        op(nvm_pkg::CMD_WRITE_PAGE, 8'h40, 8'h3C);
        rd(8'h42, 8'hA5);
        ext <= 1'b0;
        repeat (4) @(posedge clock);
        op(nvm_pkg::CMD_ERASE_BUF, 8'h00, 8'h0A);
        core(1'b1, nvm_pkg::IO_CTRL1, 8'h01);
        chk("busy", 8'h00, {7'h00, busy});
        repeat (20) @(posedge clock);
        ext <= 1'b1;
        repeat (4) @(posedge clock);
        op(nvm_pkg::CMD_NOP, 8'h00, 8'h00);
        core(1'b1, nvm_pkg::IO_CTRL2, 8'h08);
        core(1'b1, 16'h1065, 8'h5A);
        core(1'b0, 16'h1042, 8'h00);
        chk("mapped read", 8'hA5, st[15:8]);
        core(1'b1, nvm_pkg::IO_CMD, {1'b0, nvm_pkg::CMD_LOAD_BUF});
        ld(8'h06, 8'h77);
        core(1'b1, nvm_pkg::IO_CTRL2, 8'h00);
        op(nvm_pkg::CMD_WRITE_PAGE, 8'h80, 8'h3C);
        rd(8'h85, 8'h5A);
        rd(8'h86, 8'hFF);
        conclude();
    end
endmodule : tb_eeprom_nvm_command_access
